// File: core/csr_pkg.sv
package csr_pkg;

  localparam int CSR_CLK_HZ = 250_000_000;
  localparam int CSR_TB80_HZ = 80_000_000;
  localparam int CSR_TB20_HZ = 20_000_000;
  localparam int CSR_TB100K_HZ = 100_000;

  localparam int CSR_NCTR = 2;
  localparam int CSR_NPFI = 8;
  localparam int CSR_CW = 32;
  localparam int CSR_SELW = 5;
  localparam int CSR_NIN = 7;

  // Selected inputs of one counter, index into the selector bank.
  localparam int CSR_K_SRC = 0;
  localparam int CSR_K_GATE = 1;
  localparam int CSR_K_AUX = 2;
  localparam int CSR_K_A = 3;
  localparam int CSR_K_B = 4;
  localparam int CSR_K_Z = 5;
  localparam int CSR_K_ARM = 6;

  // Candidate bits: 7:0 pins, 8..10 timebases 80M/20M/100k, 11 compare,
  // 12 ref trig, 13 start trig, 14 acq sample, 15 convert, 16 gen sample,
  // 17 digin, 18 digout, 19 change detect, 20 other tc, 21 other gate,
  // 22 other source, 23 other internal out, 24 own gate.
  localparam logic [31:0] CSR_MASK_SRC = 32'h0030_0FFF;
  localparam logic [31:0] CSR_MASK_GATE = 32'h00CF_F8FF;
  localparam logic [31:0] CSR_MASK_AUX = 32'h01E0_38FF;
  localparam logic [31:0] CSR_MASK_ENC = 32'h0000_08FF;
  localparam logic [31:0] CSR_MASK_ARM = 32'h0080_38FF;
  localparam logic [6:0][31:0] CSR_MASKS = {CSR_MASK_ARM, CSR_MASK_ENC,
    CSR_MASK_ENC, CSR_MASK_ENC, CSR_MASK_AUX, CSR_MASK_GATE, CSR_MASK_SRC};

  localparam logic [31:0] CSR_COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] CSR_ONE = 32'h0000_0001;

  // Pin route codes: 0 or above 8 off, else 1 + 4 * counter + signal.
  localparam logic [3:0] CSR_RT_OFF = 4'h0;
  localparam logic [3:0] CSR_RT_LAST = 4'h8;

  typedef enum logic [2:0] {
    CSR_EDGE, CSR_QUAD, CSR_TWOP, CSR_SEP, CSR_DOWN
  } csr_mode_t;

  typedef enum logic [1:0] {
    CSR_G_NONE, CSR_G_START, CSR_G_PAUSE, CSR_G_SAVE
  } csr_gate_t;

endpackage

// File: core/csr_insel.sv
`timescale 1ns/1ps
module csr_insel
  import csr_pkg::*;
#(
  parameter logic [31:0] MASK = 32'hFFFF_FFFF
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [31:0]         cand,
  input  wire logic [CSR_SELW-1:0] sel,
  input  wire logic                fall,
  output logic                     level,
  output logic                     edge_p
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } csr_insel_t;

  csr_insel_t s_reg;
  csr_insel_t s_next;

  // A code outside the mask picks a constant low, never a stray input.
  always_comb begin
    s_next = s_reg;
    s_next.meta = cand[sel] & MASK[sel];
    s_next.sync = s_reg.meta;
    s_next.prev = s_reg.sync;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.sync;
  assign edge_p = (s_reg.sync != s_reg.prev) & (s_reg.sync ^ fall);

endmodule // csr_insel

// File: core/csr_top.sv
`timescale 1ns/1ps
// Contract
// - Two identical counters, 0 and 1, each with own timing signals.
// - Timing signals are selectable onto the programmable function pins.
// - Each active source edge increments or decrements the counter.
// - Source is timebase or measured input depending on application.
// - Source selector: three timebases, pins, compare, other tc or gate.
// - Gate can start, stop, or latch the count into the save register.
// - Gate selector: pins, acquisition timing, clocks, events, other counter.
// - Aux edge opens an edge separation, the gate edge closes it.
// - Aux selector: pins, triggers, compare, other counter, own gate.
// - In edge counting the second phase input may set direction.
// - Phases and index decode quadrature or two-pulse encoders.
// - Each phase and index input selects a pin or compare event.
// - Direction input is the same signal as the second phase input.
// - Nothing counts or outputs until the counter is armed.
// - Once armed, count at once, wait for a gate edge, or in edge separation wait for an aux edge.
// - Arm by software command or a selected hardware arm signal.
// - Hardware arm may also come from the other internal output.
// - Output operations use arm and a start trigger together.
// - Terminal count asserts whenever the counter value is zero.
// - Internal output pulses or toggles on terminal count.
// - Internal output polarity is selectable in both modes.
// - Source, gate, index and internal output route to any pin.
// - A start or pause trigger drives the counter gate input.
module csr_top
  import csr_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic [CSR_NPFI-1:0]           programmable_function_pin,
  input  wire logic                          cmp_event,
  input  wire logic                          acq_reference_trigger,
  input  wire logic                          acq_start_trigger,
  input  wire logic                          acq_sample_clock,
  input  wire logic                          acq_convert_clock,
  input  wire logic                          gen_sample_clock,
  input  wire logic                          digin_sample_clock,
  input  wire logic                          digout_sample_clock,
  input  wire logic                          change_event,
  input  wire logic [1:0]                    sw_arm,
  input  wire logic [1:0]                    disarm,
  input  wire logic [1:0]                    hardware_arm_input_en,
  input  wire csr_mode_t [1:0]               mode,
  input  wire csr_gate_t [1:0]               gate_mode,
  input  wire logic [1:0][CSR_SELW-1:0]      src_sel,
  input  wire logic [1:0][CSR_SELW-1:0]      gate_sel,
  input  wire logic [1:0][CSR_SELW-1:0]      aux_sel,
  input  wire logic [1:0][CSR_SELW-1:0]      a_sel,
  input  wire logic [1:0][CSR_SELW-1:0]      b_sel,
  input  wire logic [1:0][CSR_SELW-1:0]      z_sel,
  input  wire logic [1:0][CSR_SELW-1:0]      arm_sel,
  input  wire logic [1:0]                    src_fall,
  input  wire logic [1:0]                    gate_fall,
  input  wire logic [1:0]                    aux_fall,
  input  wire logic [1:0]                    dir_up,
  input  wire logic [1:0]                    dir_from_b,
  input  wire logic [1:0]                    out_toggle,
  input  wire logic [1:0]                    out_pol,
  input  wire logic [1:0][CSR_CW-1:0]        load_value,
  input  wire logic [CSR_NPFI-1:0][3:0]      pfi_route,
  output logic [1:0][CSR_CW-1:0]             count_value,
  output logic [1:0][CSR_CW-1:0]             save_value,
  output logic [1:0]                         armed,
  output logic [1:0]                         running,
  output logic [1:0]                         terminal_count_flag,
  output logic [1:0]                         internal_out,
  output logic [CSR_NPFI-1:0]                pfi_out,
  output logic [CSR_NPFI-1:0]                pfi_oe
);

  typedef struct packed {
    logic [2:0][31:0]       acc;
    logic [2:0]             tb;
    logic [1:0]             armed;
    logic [1:0]             run;
    logic [1:0]             sepd;
    logic [1:0]             tc;
    logic [1:0]             raw;
    logic [1:0]             out;
    logic [1:0][CSR_CW-1:0] count;
    logic [1:0][CSR_CW-1:0] save;
    logic [CSR_NPFI-1:0]    pfo;
    logic [CSR_NPFI-1:0]    pfoe;
  } csr_top_state_t;

  localparam logic [2:0][31:0] TB_HZ = {32'(CSR_TB100K_HZ),
    32'(CSR_TB20_HZ), 32'(CSR_TB80_HZ)};

  logic [1:0]                    rst_pipe_reg;
  logic                          rst_n;
  csr_top_state_t                s_reg;
  csr_top_state_t                s_next;
  logic [1:0][31:0]              cand;
  logic [1:0][6:0][CSR_SELW-1:0] sel;
  logic [1:0][6:0]               fall;
  logic [1:0][6:0]               lv;
  logic [1:0][6:0]               ed;

  // Fractional divider step; the 80M and 20M timebases are not integer ratios of the
  // system clock, so their enables carry one cycle of jitter.
  function automatic logic [32:0] tb_step(input logic [31:0] acc,
                                          input logic [31:0] hz);
    logic [31:0] sum;
    sum = acc + hz;
    if (sum >= 32'(CSR_CLK_HZ)) begin
      tb_step = {1'b1, sum - 32'(CSR_CLK_HZ)};
    end else begin
      tb_step = {1'b0, sum};
    end
  endfunction

  // Picks the level seen on a pin route code from the old state.
  function automatic logic route_pick(input logic [3:0] code,
                                      input logic [1:0][6:0] lvl,
                                      input logic [1:0] outs);
    logic [3:0] c;
    c = code - 4'h1;
    case (c[1:0])
      2'h0:    route_pick = lvl[c[2]][CSR_K_SRC];
      2'h1:    route_pick = lvl[c[2]][CSR_K_GATE];
      2'h2:    route_pick = lvl[c[2]][CSR_K_Z];
      default: route_pick = outs[c[2]];
    endcase
  endfunction

  // Reset asserts at once but releases through two flops.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  for (genvar gi = 0; gi < CSR_NCTR; gi++) begin : g_ctr
    localparam int O = 1 - gi;
    assign cand[gi] = {7'h00,
      lv[gi][CSR_K_GATE],
      s_reg.out[O],
      lv[O][CSR_K_SRC], lv[O][CSR_K_GATE],
      s_reg.tc[O],
      change_event, digout_sample_clock, digin_sample_clock,
      gen_sample_clock, acq_convert_clock, acq_sample_clock,
      acq_start_trigger, acq_reference_trigger, cmp_event,
      s_reg.tb,
      programmable_function_pin};
    // The second phase select doubles as the direction select.
    assign sel[gi] = {arm_sel[gi], z_sel[gi], b_sel[gi], a_sel[gi],
      aux_sel[gi], gate_sel[gi], src_sel[gi]};
    assign fall[gi] = {4'h0, aux_fall[gi], gate_fall[gi], src_fall[gi]};
    for (genvar gk = 0; gk < CSR_NIN; gk++) begin : g_in
      csr_insel #(
        .MASK (CSR_MASKS[gk])
      ) u_sel (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .cand    (cand[gi]),
        .sel     (sel[gi][gk]),
        .fall    (fall[gi][gk]),
        .level   (lv[gi][gk]),
        .edge_p  (ed[gi][gk])
      );
    end
  end

  always_comb begin
    logic [32:0]       st;
    logic [CSR_CW-1:0] cnt;
    logic              en;
    logic              up;
    logic              tcn;
    st = '0;
    cnt = '0;
    en = 1'b0;
    up = 1'b0;
    tcn = 1'b0;
    s_next = s_reg;
    for (int j = 0; j < 3; j++) begin
      st = tb_step(s_reg.acc[j], TB_HZ[j]);
      s_next.tb[j] = st[32];
      s_next.acc[j] = st[31:0];
    end
    for (int i = 0; i < CSR_NCTR; i++) begin
      cnt = s_reg.count[i];
      if (disarm[i]) begin
        s_next.armed[i] = 1'b0;
        s_next.run[i] = 1'b0;
      end else if (!s_reg.armed[i]) begin
        if (sw_arm[i] || (hardware_arm_input_en[i] && ed[i][CSR_K_ARM])) begin
          s_next.armed[i] = 1'b1;
          s_next.sepd[i] = 1'b0;
          cnt = (mode[i] == CSR_SEP) ? CSR_COUNT_RST : load_value[i];
          s_next.run[i] = (gate_mode[i] != CSR_G_START) &&
                          (mode[i] != CSR_SEP);
        end
      end else begin
        // Output work waits for both arm and the start trigger.
        if (gate_mode[i] == CSR_G_START && !s_reg.run[i] &&
            ed[i][CSR_K_GATE]) begin
          s_next.run[i] = 1'b1;
        end
        if (mode[i] == CSR_SEP) begin
          if (!s_reg.run[i] && !s_reg.sepd[i] && ed[i][CSR_K_AUX]) begin
            s_next.run[i] = 1'b1;
            cnt = CSR_COUNT_RST;
          end
          if (s_reg.run[i] && ed[i][CSR_K_GATE]) begin
            s_next.save[i] = cnt;
            s_next.run[i] = 1'b0;
            s_next.sepd[i] = 1'b1;
          end
        end
        if (gate_mode[i] == CSR_G_SAVE && ed[i][CSR_K_GATE]) begin
          s_next.save[i] = cnt;
        end
        en = s_reg.run[i] &&
             (gate_mode[i] != CSR_G_PAUSE || lv[i][CSR_K_GATE]);
        up = dir_from_b[i] ? lv[i][CSR_K_B] : dir_up[i];
        case (mode[i])
          CSR_EDGE: begin
            if (en && ed[i][CSR_K_SRC]) begin
              cnt = up ? cnt + CSR_ONE : cnt - CSR_ONE;
            end
          end
          CSR_QUAD: begin
            if (en && ed[i][CSR_K_A]) begin
              cnt = lv[i][CSR_K_B] ? cnt - CSR_ONE : cnt + CSR_ONE;
            end
            if (en && ed[i][CSR_K_Z]) begin
              cnt = load_value[i];
            end
          end
          CSR_TWOP: begin
            if (en && ed[i][CSR_K_A]) begin
              cnt = cnt + CSR_ONE;
            end
            if (en && ed[i][CSR_K_B]) begin
              cnt = cnt - CSR_ONE;
            end
          end
          CSR_SEP: begin
            if (s_reg.run[i] && ed[i][CSR_K_SRC]) begin
              cnt = cnt + CSR_ONE;
            end
          end
          default: begin
            // Down count reloads at zero; with a start trigger it then
            // rests until the next trigger, which makes it retriggerable.
            if (en && ed[i][CSR_K_SRC]) begin
              if (cnt == CSR_COUNT_RST) begin
                cnt = load_value[i];
                if (gate_mode[i] == CSR_G_START) begin
                  s_next.run[i] = 1'b0;
                end
              end else begin
                cnt = cnt - CSR_ONE;
              end
            end
          end
        endcase
      end
      s_next.count[i] = cnt;
      tcn = (cnt == CSR_COUNT_RST);
      s_next.tc[i] = tcn;
      // The output only moves once armed, so no pulse leaks at reset.
      if (!s_reg.armed[i]) begin
        s_next.raw[i] = 1'b0;
      end else if (out_toggle[i]) begin
        s_next.raw[i] = s_reg.raw[i] ^ (tcn & ~s_reg.tc[i]);
      end else begin
        s_next.raw[i] = tcn;
      end
      s_next.out[i] = s_next.raw[i] ^ out_pol[i];
    end
    for (int p = 0; p < CSR_NPFI; p++) begin
      s_next.pfoe[p] = (pfi_route[p] != CSR_RT_OFF) &&
                       (pfi_route[p] <= CSR_RT_LAST);
      s_next.pfo[p] = s_next.pfoe[p] &&
                      route_pick(pfi_route[p], lv, s_reg.out);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      // A cleared count is already a terminal count, so the flags start set.
      s_reg.tc <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count_value = s_reg.count;
  assign save_value = s_reg.save;
  assign armed = s_reg.armed;
  assign running = s_reg.run;
  assign terminal_count_flag = s_reg.tc;
  assign internal_out = s_reg.out;
  assign pfi_out = s_reg.pfo;
  assign pfi_oe = s_reg.pfoe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_tc_zero;
    terminal_count_flag[0] == (count_value[0] == CSR_COUNT_RST);
  endproperty
  a_tc_zero: assert property (p_tc_zero)
    else $error("terminal count disagrees with zero count");

  property p_idle_hold;
    !armed[1] ##1 !armed[1] |-> $stable(count_value[1]);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("unarmed counter changed its value");

  property p_sw_arm;
    sw_arm[0] && !armed[0] && !disarm[0] |=> armed[0];
  endproperty
  a_sw_arm: assert property (p_sw_arm)
    else $error("software arm not taken");

  property p_wait_gate;
    $rose(armed[0]) && $past(gate_mode[0] == CSR_G_START) |-> !running[0];
  endproperty
  a_wait_gate: assert property (p_wait_gate)
    else $error("counter ran before its start trigger");

  property p_sep_save;
    armed[1] && running[1] && mode[1] == CSR_SEP && ed[1][CSR_K_GATE] &&
    !ed[1][CSR_K_SRC] && !disarm[1]
    |=> save_value[1] == $past(count_value[1]) && !running[1];
  endproperty
  a_sep_save: assert property (p_sep_save)
    else $error("separation not closed by gate edge");

  property p_toggle;
    $rose(terminal_count_flag[0]) && $past(out_toggle[0]) &&
    $past(armed[0]) && $stable(out_pol[0]) && $past(out_pol[0]) ==
    $past(out_pol[0], 2)
    |-> internal_out[0] != $past(internal_out[0]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output did not toggle on terminal count");

  property p_pulse;
    $past(armed[0]) && !$past(out_toggle[0])
    |-> internal_out[0] == (terminal_count_flag[0] ^ $past(out_pol[0]));
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse output wrong for polarity");

  property p_edge_up;
    armed[0] && running[0] && mode[0] == CSR_EDGE &&
    gate_mode[0] == CSR_G_NONE && ed[0][CSR_K_SRC] && dir_from_b[0] &&
    lv[0][CSR_K_B] && !disarm[0]
    |=> count_value[0] == $past(count_value[0]) + CSR_ONE;
  endproperty
  a_edge_up: assert property (p_edge_up)
    else $error("direction from second phase not applied");

  property p_route_out;
    pfi_route[0] == 4'h4 |=> pfi_oe[0] &&
      pfi_out[0] == $past(internal_out[0]);
  endproperty
  a_route_out: assert property (p_route_out)
    else $error("internal output not routed to pin");

  c_sep_done: cover property (armed[1] && $fell(running[1]) &&
    mode[1] == CSR_SEP);
  c_reload: cover property (mode[0] == CSR_DOWN && $rose(
    terminal_count_flag[0]) ##[1:50] $fell(terminal_count_flag[0]));
  c_hardware_arm_input: cover property (hardware_arm_input_en[1] && $rose(armed[1]));

endmodule // csr_top

// File: verification/csr_pin_model.sv
`timescale 1ns/1ps
module csr_pin_model
  import csr_pkg::*;
(
  input  wire logic          clk_sys,
  output logic [CSR_NPFI-1:0] pins,
  output logic [8:0]          events
);
  // Bits 7:0 are pins, 16:8 are compare, ref, start, acq sample, convert,
  // gen sample, digin, digout and change events.
  logic [16:0] drv;

  assign pins   = drv[7:0];
  assign events = drv[16:8];

  initial begin
    drv = '0;
  end

  // Widths of two to four cycles keep the two-cycle minimum spacing that
  // the input synchronisers need, while varying how fast we answer.
  task automatic pulse(input int unsigned idx);
    int unsigned hi;
    hi = 2 + $urandom % 3;
    @(posedge clk_sys);
    #1;
    drv[idx] = 1'b1;
    repeat (hi) @(posedge clk_sys);
    #1;
    drv[idx] = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic hold(input int unsigned idx, input logic v);
    @(posedge clk_sys);
    #1;
    drv[idx] = v;
  endtask
endmodule // csr_pin_model

// File: verification/counter_signal_routing_bench.sv
`timescale 1ns/1ps
module counter_signal_routing_bench
  import csr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b   = 1'b0;
  logic [1:0] sw_arm, disarm, hardware_arm_input_en, src_fall, gate_fall, aux_fall;
  logic [1:0] dir_up, dir_from_b, out_toggle, out_pol;
  csr_mode_t [1:0] mode;
  csr_gate_t [1:0] gate_mode;
  logic [1:0][CSR_SELW-1:0] src_sel, gate_sel, aux_sel, a_sel, b_sel;
  logic [1:0][CSR_SELW-1:0] z_sel, arm_sel;
  logic [1:0][CSR_CW-1:0]   load_value, count_value, save_value;
  logic [CSR_NPFI-1:0][3:0] pfi_route;
  logic [1:0] armed, running, terminal_count_flag, internal_out;
  logic [CSR_NPFI-1:0] pfi_out, pfi_oe, model_pins, pin_wire;
  logic [8:0] ev;
  int errors = 0;
  int checks_done = 0;
  int c, n;
  logic [31:0] ld, cnt;
  logic a;

  always #2 clk_sys = ~clk_sys;

  // A pin that the block drives wins over the far side.
  assign pin_wire = (pfi_oe & pfi_out) | (~pfi_oe & model_pins);

  csr_pin_model u_pins (.clk_sys(clk_sys), .pins(model_pins), .events(ev));

  csr_top u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .programmable_function_pin(pin_wire),
    .cmp_event(ev[0]), .acq_reference_trigger(ev[1]),
    .acq_start_trigger(ev[2]), .acq_sample_clock(ev[3]),
    .acq_convert_clock(ev[4]), .gen_sample_clock(ev[5]),
    .digin_sample_clock(ev[6]), .digout_sample_clock(ev[7]),
    .change_event(ev[8]), .sw_arm(sw_arm), .disarm(disarm),
    .hardware_arm_input_en(hardware_arm_input_en), .mode(mode), .gate_mode(gate_mode),
    .src_sel(src_sel), .gate_sel(gate_sel), .aux_sel(aux_sel),
    .a_sel(a_sel), .b_sel(b_sel), .z_sel(z_sel), .arm_sel(arm_sel),
    .src_fall(src_fall), .gate_fall(gate_fall), .aux_fall(aux_fall),
    .dir_up(dir_up), .dir_from_b(dir_from_b), .out_toggle(out_toggle),
    .out_pol(out_pol), .load_value(load_value), .pfi_route(pfi_route),
    .count_value(count_value), .save_value(save_value), .armed(armed),
    .running(running), .terminal_count_flag(terminal_count_flag),
    .internal_out(internal_out), .pfi_out(pfi_out), .pfi_oe(pfi_oe));

  function automatic logic [31:0] exp_count(logic [31:0] l, int k, bit up);
    return up ? l + 32'(k) : l - 32'(k);
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic rearm(input int k, input logic [31:0] l);
    load_value[k] = l;
    disarm[k] = 1'b1;
    tick(1);
    disarm[k] = 1'b0;
    sw_arm[k] = 1'b1;
    tick(1);
    sw_arm[k] = 1'b0;
    tick(1);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    summarize();
  end

  initial begin
    {sw_arm, disarm, hardware_arm_input_en, src_fall, gate_fall, aux_fall} = '0;
    {dir_up, dir_from_b, out_toggle, out_pol} = 8'h0F;
    mode[0] = CSR_EDGE;
    mode[1] = CSR_EDGE;
    gate_mode[0] = CSR_G_NONE;
    gate_mode[1] = CSR_G_NONE;
    {src_sel, gate_sel, aux_sel, a_sel, b_sel, z_sel, arm_sel} = {14{5'h07}};
    load_value = '0;
    pfi_route = '0;
    void'($urandom(69517));
    tick(4);
    rst_b = 1'b1;
    tick(8);
    check("count0", count_value[0], 32'h0000_0000);
    check("tc", 32'(terminal_count_flag), 32'h0000_0003);
    check("oe", 32'(pfi_oe), 32'h0000_0000);
    src_sel[0] = 5'h00;
    tick(4);
    repeat (2) u_pins.pulse(0);
    tick(3);
    check("idle count", count_value[0], 32'h0000_0000);
    $display("test reset and idle done");
    u_pins.hold(1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      c = i % 2;
      ld = $urandom;
      n = 1 + $urandom % 6;
      mode[c] = (i == 3) ? CSR_QUAD : CSR_EDGE;
      dir_up[c] = (i != 1);
      dir_from_b[c] = (i == 2);
      src_fall[c] = 1'($urandom % 2);
      {src_sel[c], a_sel[c], b_sel[c]} = {5'h00, 5'h00, 5'h01};
      tick(4);
      rearm(c, ld);
      check("armed", 32'(armed[c]), 32'h0000_0001);
      check("running", 32'(running[c]), 32'h0000_0001);
      repeat (n) u_pins.pulse(0);
      tick(3);
      check("count", count_value[c], exp_count(ld, n, i < 3 && i != 1));
    end
    mode[0] = CSR_EDGE;
    dir_up[0] = 1'b1;
    src_sel[0] = 5'h08;
    rearm(0, 32'h0000_0000);
    tick(100);
    cnt = count_value[0];
    check("timebase", 32'(cnt >= 29 && cnt <= 34), 32'h0000_0001);
    src_sel[0] = 5'h00;
    $display("test edge counting done");
    c = 0;
    n = 2 + $urandom % 4;
    mode[c] = CSR_DOWN;
    out_toggle[c] = 1'b0;
    out_pol[c] = 1'($urandom % 2);
    dir_from_b[c] = 1'b0;
    src_sel[c] = 5'h00;
    rearm(c, 32'(n));
    check("tc armed", 32'(terminal_count_flag[c]), 32'h0000_0000);
    repeat (n) u_pins.pulse(0);
    tick(3);
    check("down", count_value[c], 32'h0000_0000);
    check("tc zero", 32'(terminal_count_flag[c]), 32'h0000_0001);
    check("pulse out", 32'(internal_out[c]), {31'h0000_0000, ~out_pol[c]});
    out_toggle[c] = 1'b1;
    rearm(c, 32'(n));
    repeat (n - 1) u_pins.pulse(0);
    tick(3);
    a = internal_out[c];
    u_pins.pulse(0);
    tick(3);
    check("toggle out", 32'(internal_out[c]), {31'h0000_0000, ~a});
    $display("test terminal count done");
    ld = $urandom;
    n = 1 + $urandom % 5;
    mode[0] = CSR_EDGE;
    gate_mode[0] = CSR_G_SAVE;
    gate_sel[0] = 5'h02;
    gate_fall[0] = 1'($urandom % 2);
    tick(4);
    rearm(0, ld);
    repeat (n) u_pins.pulse(0);
    u_pins.pulse(2);
    tick(3);
    check("save", save_value[0], exp_count(ld, n, 1));
    mode[1] = CSR_SEP;
    gate_mode[1] = CSR_G_NONE;
    {gate_sel[1], aux_sel[1]} = {5'h02, 5'h03};
    aux_fall[1] = 1'($urandom % 2);
    tick(4);
    rearm(1, $urandom);
    check("sep count", count_value[1], 32'h0000_0000);
    u_pins.pulse(0);
    check("sep wait", 32'(running[1]), 32'h0000_0000);
    u_pins.pulse(3);
    tick(3);
    check("sep open", 32'(running[1]), 32'h0000_0001);
    repeat (n) u_pins.pulse(0);
    u_pins.pulse(2);
    tick(3);
    check("sep save", save_value[1], 32'(n));
    u_pins.pulse(3);
    u_pins.pulse(0);
    tick(3);
    check("sep closed", 32'(running[1]), 32'h0000_0000);
    $display("test save and separation done");
    gate_mode[0] = CSR_G_START;
    gate_fall[0] = 1'b0;
    ld = $urandom;
    rearm(0, ld);
    check("start wait", 32'(running[0]), 32'h0000_0000);
    u_pins.pulse(0);
    tick(3);
    check("no count", count_value[0], ld);
    u_pins.pulse(2);
    tick(3);
    check("started", 32'(running[0]), 32'h0000_0001);
    u_pins.pulse(0);
    tick(3);
    check("start count", count_value[0], exp_count(ld, 1, 1));
    mode[1] = CSR_EDGE;
    {hardware_arm_input_en[1], arm_sel[1]} = {1'b1, 5'h0D};
    disarm[1] = 1'b1;
    tick(1);
    disarm[1] = 1'b0;
    tick(4);
    check("hw idle", 32'(armed[1]), 32'h0000_0000);
    u_pins.pulse(10);
    tick(3);
    check("hardware_arm_input", 32'(armed[1]), 32'h0000_0001);
    hardware_arm_input_en[1] = 1'b0;
    $display("test start and hardware arm done");
    c = $urandom % 2;
    gate_sel[c] = 5'h02;
    pfi_route[5] = 4'(2 + 4 * c);
    pfi_route[6] = 4'(4 + 4 * c);
    pfi_route[0] = 4'h4;
    pfi_route[7] = 4'(3 + 4 * c);
    z_sel[c] = 5'h0B;
    u_pins.hold(2, 1'b1);
    tick(6);
    check("route gate", 32'({pfi_oe[5], pfi_out[5]}), 32'h0000_0003);
    check("route off", 32'(pfi_oe[4]), 32'h0000_0000);
    u_pins.hold(2, 1'b0);
    tick(6);
    check("route low", 32'(pfi_out[5]), 32'h0000_0000);
    check("route out", 32'(pfi_out[6]), 32'(internal_out[c]));
    check("route out0", 32'(pfi_out[0]), 32'(internal_out[0]));
    // Every acquisition event must reach a pin through the gate selector.
    for (int k = 0; k < 9; k++) begin
      gate_sel[c] = 5'(11 + k);
      u_pins.hold(8 + k, 1'b1);
      tick(6);
      check("event gate", 32'(pfi_out[5]), 32'h0000_0001);
      check("route z", 32'(pfi_out[7]), 32'(k == 0));
      u_pins.hold(8 + k, 1'b0);
      tick(6);
      check("event low", 32'(pfi_out[5]), 32'h0000_0000);
    end
    $display("test pin routing done");
    summarize();
  end
endmodule // counter_signal_routing_bench
